/* verilog/mode_reg_two_three.sv */
/*
 Second and third mode registers with write latency, self-refresh rate, write termination and
 calibration readout. Assumes the command decoder gives a one-cycle mode-register-set strobe
 with bank and address bits, and a read-beat strobe for each data beat.
*/
// Overview of operation
// RQ1 - Controller writes only when idle, waits after
// RQ2 - Registers hold until rewritten; array untouched
// RQ3 - Controller zeroes reserved bits of register two
// RQ4 - Register two bits 5:3 set write column latency
// RQ5 - Total write latency is column plus additive
// RQ6 - Controller matches column latency to clock
// RQ7 - Bit 6 enables automatic 2X self-refresh
// RQ8 - Without options, self-refresh runs at 1X
// RQ9 - Bit 7 forces 2X self-refresh always
// RQ10 - Controller never sets both refresh options
// RQ11 - Bits 10:9 select write termination; zero disables
// RQ12 - Write termination replaces nominal during write burst
// RQ13 - Nominal and write termination are independent
// RQ14 - No write termination during write leveling
// RQ15 - Controller zeroes reserved bits of register three
// RQ16 - Bit 2 clear: normal array access
// RQ17 - Bit 2 set: reads return calibration data
// RQ18 - Selection 00 picks the fixed pattern
// RQ19 - Controller precharges all banks before enabling
// RQ20 - Controller issues only reads while enabled
// RQ21 - Reset still works in calibration mode
// RQ22 - Pattern alternates starting with zero
// RQ23 - Bank address 010 and 011 select registers
// RQ24 - Additive latency zero, minus one or minus two
// RQ25 - Beat zero is pattern LSB, seven MSB
// RQ26 - Controller avoids reserved calibration selections
`timescale 1ns/10ps
`include "mode_reg_map.svh"
module mode_reg_two_three #(
	parameter int WIDTH = `MR_WIDTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Mode register set command
	input wire logic mrs_strobe,
	input wire logic [2:0] bank_addr,
	input wire logic [WIDTH-1:0] addr,
	// Settings held in other mode registers
	input wire logic [3:0] read_column_latency,
	input wire logic [1:0] additive_latency,
	input wire logic [2:0] nominal_termination,
	input wire logic write_level_mode,
	// Environment
	input wire logic temp_near_85c,
	// Write path events
	input wire logic wr_burst_start,
	input wire logic wr_burst_end,
	// Read path
	input wire logic read_beat,
	input wire logic [2:0] beat_index,
	input wire logic array_rd_bit,
	// Outputs
	output logic [3:0] write_column_latency,
	output logic [4:0] total_write_latency,
	output logic selfrefresh_2x,
	output logic [2:0] term_select,
	output logic term_is_write,
	output logic cal_mode,
	output logic rd_bit_r,
	output logic rsvd_write_seen_r
);
	logic [WIDTH-1:0] mode_register_two_r;
	logic [WIDTH-1:0] mode_register_three_r;
	logic [3:0] add_lat_cycles;
	// Register select by bank address
	wire wr_two = mrs_strobe & (bank_addr == `SEL_MR_TWO); // [RQ23]
	wire wr_three = mrs_strobe & (bank_addr == `SEL_MR_THREE); // [RQ23]
	// Reserved bits are stored as given; a flag records misuse for debug
	wire rsvd_hit = (wr_two & |(addr & `REG_TWO_RSVD_MASK)) | (wr_three & |(addr & `REG_THREE_RSVD_MASK));
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin // [RQ21]
			mode_register_two_r <= `MR_RESET;
			mode_register_three_r <= `MR_RESET;
			rsvd_write_seen_r <= 1'b0;
		end else begin
			if (wr_two) mode_register_two_r <= addr; // [RQ2]
			if (wr_three) mode_register_three_r <= addr; // [RQ2]
			if (rsvd_hit) rsvd_write_seen_r <= 1'b1;
		end
	end
	// Field decode
	wire [2:0] wcl_code = mode_register_two_r[`WCL_MSB:`WCL_LSB];
	wire auto_sr_en = mode_register_two_r[`AUTO_SR_BIT];
	wire forced_sr_en = mode_register_two_r[`FORCED_SR_BIT];
	wire [1:0] wterm = mode_register_two_r[`WTERM_MSB:`WTERM_LSB];
	wire cal_en = mode_register_three_r[`CAL_EN_BIT];
	wire [1:0] cal_sel = mode_register_three_r[`CAL_SEL_MSB:`CAL_SEL_LSB];
	// Code 0 is five clocks, each step one more
	assign write_column_latency = `WCL_BASE + {1'b0, wcl_code}; // [RQ4]
	always_comb begin
		unique case (additive_latency)
			`ADD_LAT_ZERO: add_lat_cycles = 4'h0;
			`ADD_LAT_RCL_MINUS1: add_lat_cycles = read_column_latency - 4'h1; // [RQ24]
			`ADD_LAT_RCL_MINUS2: add_lat_cycles = read_column_latency - 4'h2; // [RQ24]
			default: add_lat_cycles = 4'h0;
		endcase
	end
	assign total_write_latency = {1'b0, write_column_latency} + {1'b0, add_lat_cycles}; // [RQ5]
	selfrefresh_rate u_rate (
		.auto_selfrefresh_rate(auto_sr_en),
		.forced_2x_selfrefresh(forced_sr_en),
		.temp_near_85c(temp_near_85c),
		.rate_2x(selfrefresh_2x)
	);
	write_termination_ctrl u_term (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.write_termination(wterm),
		.nominal_termination(nominal_termination),
		.write_level_mode(write_level_mode),
		.wr_burst_start(wr_burst_start),
		.wr_burst_end(wr_burst_end),
		.term_select(term_select),
		.term_is_write(term_is_write)
	);
	// Calibration readout; reserved selections return zero
	localparam logic [7:0] CAL_PATTERN = `CAL_PATTERN; // [RQ22]
	wire [7:0] pattern_src = (cal_sel == `CAL_SEL_PATTERN) ? CAL_PATTERN : 8'h00; // [RQ18]
	wire cal_bit = pattern_src[beat_index]; // [RQ25]
	assign cal_mode = cal_en;
	wire rd_next = cal_en ? cal_bit : array_rd_bit; // [RQ16] [RQ17]
	always_ff @(posedge core_clk) begin
		if (!rst_n) rd_bit_r <= 1'b0;
		else if (read_beat) rd_bit_r <= rd_next;
	end
	// Sampled reset in the antecedent: a one-edge reset pulse must not look like a lost value
	chk_mr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n && !wr_two |=> $stable(mode_register_two_r)) else $error("mode register two changed"); // [RQ2]
	chk_mr_sel_three: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n && wr_three |=> mode_register_three_r == $past(addr)) else $error("register three not loaded"); // [RQ23]
	chk_wcl_value: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n && wr_two |=> write_column_latency == 4'h5 + {1'b0, $past(addr[5:3])})
		else $error("bad write latency"); // [RQ4]
	chk_total_lat_sum: assert property (@(posedge core_clk) disable iff (!rst_n)
		additive_latency == 2'h0 |-> total_write_latency == {1'b0, write_column_latency})
		else $error("total write latency wrong"); // [RQ5]
	chk_forced_2x: assert property (@(posedge core_clk) disable iff (!rst_n)
		forced_sr_en |-> selfrefresh_2x) else $error("forced 2X not applied"); // [RQ9]
	chk_rate_1x: assert property (@(posedge core_clk) disable iff (!rst_n)
		!forced_sr_en && !(auto_sr_en && temp_near_85c) |-> !selfrefresh_2x) else $error("rate not 1X"); // [RQ8]
	chk_auto_2x_hot: assert property (@(posedge core_clk) disable iff (!rst_n)
		auto_sr_en && temp_near_85c |-> selfrefresh_2x) else $error("auto 2X missed"); // [RQ7]
	chk_cal_pattern: assert property (@(posedge core_clk) disable iff (!rst_n)
		read_beat && cal_en && cal_sel == 2'h0 |=> rd_bit_r == $past(beat_index[0]))
		else $error("calibration beat wrong"); // [RQ22]
	chk_normal_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		read_beat && !cal_en |=> rd_bit_r == $past(array_rd_bit)) else $error("array data lost"); // [RQ16]
	chk_wterm_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		wterm == 2'h0 && !term_is_write |=> !term_is_write) else $error("termination with zero select"); // [RQ11]
	cov_reg_two_write: cover property (@(posedge core_clk) disable iff (!rst_n) wr_two);
	cov_cal_burst: cover property (@(posedge core_clk) disable iff (!rst_n) cal_en && read_beat [*8]);
	cov_cal_exit: cover property (@(posedge core_clk) disable iff (!rst_n) cal_en ##1 !cal_en);
endmodule // mode_reg_two_three

/* common/mode_reg_map.svh */
/*
 Bit positions, field widths, reset values and encodings of the second and third mode registers.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef MODE_REG_MAP_SVH
`define MODE_REG_MAP_SVH
`define MR_WIDTH 17
`define MR_RESET 17'h00000
`define SEL_MR_TWO 3'h2
`define SEL_MR_THREE 3'h3
`define WCL_LSB 3
`define WCL_MSB 5
`define WCL_BASE 4'h5
`define AUTO_SR_BIT 6
`define FORCED_SR_BIT 7
`define WTERM_LSB 9
`define WTERM_MSB 10
`define CAL_EN_BIT 2
`define CAL_SEL_LSB 0
`define CAL_SEL_MSB 1
`define CAL_SEL_PATTERN 2'h0
`define CAL_PATTERN 8'hAA
`define REG_TWO_RSVD_MASK 17'h13907
`define REG_THREE_RSVD_MASK 17'h13FF8
`define ADD_LAT_ZERO 2'h0
`define ADD_LAT_RCL_MINUS1 2'h1
`define ADD_LAT_RCL_MINUS2 2'h2
`endif

/* common/mode_reg_pkg.sv */
/*
 Types shared by the mode register bank.
 Assumes no other package.
*/
package mode_reg_pkg;
	typedef enum logic [1:0] {TERM_NOMINAL, TERM_WRITE} term_state_t;
	typedef logic [16:0] mode_word_t;
endpackage

/* verilog/selfrefresh_rate.sv */
/*
 Picks the self-refresh rate from the automatic and forced options and the case temperature.
 Assumes a synchronous warm flag from a temperature sensor.
*/
`timescale 1ns/10ps
`include "mode_reg_map.svh"
module selfrefresh_rate (
	// Settings
	input wire logic auto_selfrefresh_rate,
	input wire logic forced_2x_selfrefresh,
	// Temperature
	input wire logic temp_near_85c,
	// Result
	output logic rate_2x
);
	wire auto_2x = auto_selfrefresh_rate & temp_near_85c; // [RQ7]
	// Forced option ignores temperature; auto option gives 2X only when warm; neither gives 1X
	assign rate_2x = forced_2x_selfrefresh | auto_2x; // [RQ8] [RQ9]
endmodule // selfrefresh_rate

/* verilog/write_termination_ctrl.sv */
/*
 Dynamic write termination selector for one data group.
 Assumes write burst start and end pulses from the write path.
*/
`timescale 1ns/10ps
`include "mode_reg_map.svh"
module write_termination_ctrl (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Settings
	input wire logic [1:0] write_termination,
	input wire logic [2:0] nominal_termination,
	input wire logic write_level_mode,
	// Write burst events
	input wire logic wr_burst_start,
	input wire logic wr_burst_end,
	// Termination out
	output logic [2:0] term_select,
	output logic term_is_write
);
	mode_reg_pkg::term_state_t state_r, state_nxt;
	wire dyn_en = (write_termination != 2'h0) & ~write_level_mode; // [RQ11] [RQ14]
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			mode_reg_pkg::TERM_NOMINAL: if (wr_burst_start && dyn_en) state_nxt = mode_reg_pkg::TERM_WRITE; // [RQ12]
			mode_reg_pkg::TERM_WRITE: if (wr_burst_end || !dyn_en) state_nxt = mode_reg_pkg::TERM_NOMINAL; // [RQ12]
			// Unused state codes fall back to nominal termination
			default: state_nxt = mode_reg_pkg::TERM_NOMINAL;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) state_r <= mode_reg_pkg::TERM_NOMINAL;
		else state_r <= state_nxt;
	end
	// Nominal code 0 means high impedance; write value works regardless
	assign term_is_write = (state_r == mode_reg_pkg::TERM_WRITE);
	assign term_select = term_is_write ? {1'b0, write_termination} : nominal_termination; // [RQ13]
	chk_write_term_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		write_level_mode |=> !term_is_write) else $error("write termination during leveling"); // [RQ14]
	chk_term_return: assert property (@(posedge core_clk) disable iff (!rst_n)
		term_is_write && wr_burst_end |=> !term_is_write) else $error("termination not restored"); // [RQ12]
	cov_write_term: cover property (@(posedge core_clk) disable iff (!rst_n) wr_burst_start && dyn_en ##1 term_is_write);
endmodule // write_termination_ctrl

/* bench/ctrl_model.sv */
/*
 Controller-side model that issues mode-register-set commands.
 Assumes the caller only issues commands while all banks are idle and no burst runs.
*/
`timescale 1ns/10ps
`include "mode_reg_map.svh"
module ctrl_model (
	// Clock
	input wire logic core_clk,
	// Mode register set command
	output logic mrs_strobe,
	output logic [2:0] bank_addr,
	output logic [16:0] addr
);
	initial begin
		mrs_strobe = 1'b0;
		bank_addr = 3'h0;
		addr = 17'h00000;
	end
	// Only called between bursts with banks idle
	task automatic mrs(input logic [2:0] bank, input logic [16:0] value);
		logic [16:0] clean;
		clean = value & ~((bank == `SEL_MR_THREE) ? `REG_THREE_RSVD_MASK : `REG_TWO_RSVD_MASK);
		if (bank == `SEL_MR_TWO && clean[`FORCED_SR_BIT]) begin
			clean[`AUTO_SR_BIT] = 1'b0;
		end
		if (bank == `SEL_MR_THREE) begin
			clean[1:0] = `CAL_SEL_PATTERN;
		end
		@(posedge core_clk);
		mrs_strobe <= 1'b1;
		bank_addr <= bank;
		addr <= clean;
		@(posedge core_clk);
		mrs_strobe <= 1'b0;
		// Released lines show no stale value
		bank_addr <= ~bank;
		addr <= ~clean;
	endtask
endmodule // ctrl_model

/* bench/tb_top.sv */
/*
 Self-checking bench for the second and third mode registers.
 Assumes a 100 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "mode_reg_map.svh"
module tb_top;
	logic core_clk = 1'b0, rst_n = 1'b0, write_level_mode = 1'b0, temp_near_85c = 1'b0;
	logic wr_burst_start = 1'b0, wr_burst_end = 1'b0, read_beat = 1'b0, array_rd_bit = 1'b0;
	logic [2:0] nominal_termination = 3'h0, beat_index = 3'h0, bank_addr, term_select;
	logic [3:0] read_column_latency = 4'h9, write_column_latency;
	logic [1:0] additive_latency = 2'h0;
	logic [16:0] addr;
	logic [4:0] total_write_latency;
	logic mrs_strobe, selfrefresh_2x, term_is_write, cal_mode, rd_bit_r, rsvd_write_seen_r;
	int n_mismatch = 0, check_count = 0, cycles = 0;
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	ctrl_model u_ctrl_model (.core_clk(core_clk), .mrs_strobe(mrs_strobe), .bank_addr(bank_addr), .addr(addr));
	mode_reg_two_three u_mode_reg_two_three (.core_clk(core_clk), .rst_n(rst_n), .mrs_strobe(mrs_strobe),
		.bank_addr(bank_addr), .addr(addr), .read_column_latency(read_column_latency),
		.additive_latency(additive_latency), .nominal_termination(nominal_termination),
		.write_level_mode(write_level_mode), .temp_near_85c(temp_near_85c), .wr_burst_start(wr_burst_start),
		.wr_burst_end(wr_burst_end), .read_beat(read_beat), .beat_index(beat_index), .array_rd_bit(array_rd_bit),
		.write_column_latency(write_column_latency), .total_write_latency(total_write_latency),
		.selfrefresh_2x(selfrefresh_2x), .term_select(term_select), .term_is_write(term_is_write),
		.cal_mode(cal_mode), .rd_bit_r(rd_bit_r), .rsvd_write_seen_r(rsvd_write_seen_r));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One write burst; expected select worked out from the settings
	task automatic term_case(input logic [1:0] wt, input logic lvl, input logic [2:0] nom);
		u_ctrl_model.mrs(`SEL_MR_TWO, 17'(wt) << `WTERM_LSB);
		@(posedge core_clk);
		nominal_termination <= nom;
		write_level_mode <= lvl;
		wr_burst_start <= 1'b1;
		@(posedge core_clk);
		wr_burst_start <= 1'b0;
		#1;
		chk(term_is_write, 8'(wt != 2'h0 && !lvl));
		chk(term_select, (wt != 2'h0 && !lvl) ? 8'(wt) : 8'(nom));
		@(posedge core_clk);
		wr_burst_end <= 1'b1;
		@(posedge core_clk);
		wr_burst_end <= 1'b0;
		#1;
		chk(term_select, 8'(nom));
	endtask
	task automatic beat(input logic [2:0] k, input logic arr, input logic exp);
		@(posedge core_clk);
		read_beat <= 1'b1;
		beat_index <= k;
		array_rd_bit <= arr;
		@(posedge core_clk);
		read_beat <= 1'b0;
		#1;
		chk(rd_bit_r, 8'(exp));
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 1000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(write_column_latency, 8'h05);
		chk(selfrefresh_2x, 8'h00);
		chk(cal_mode, 8'h00);
		// Latency 9 suits the clock in use
		for (int c = 0; c < 8; c++) begin
			@(posedge core_clk);
			additive_latency <= c[1:0];
			u_ctrl_model.mrs(`SEL_MR_TWO, 17'(c) << `WCL_LSB);
			#1;
			chk(write_column_latency, 8'(5 + c));
			chk(total_write_latency, 8'(5 + c + (c[1:0] == 2'h1 ? 8 : c[1:0] == 2'h2 ? 7 : 0)));
		end
		u_ctrl_model.mrs(3'h0, 17'h1FFFF);
		u_ctrl_model.mrs(`SEL_MR_THREE, 17'h00000);
		#1;
		chk(write_column_latency, 8'h0C);
		for (int k = 0; k < 6; k++) begin
			@(posedge core_clk);
			temp_near_85c <= k[0];
			u_ctrl_model.mrs(`SEL_MR_TWO, 17'(k[2:1]) << `AUTO_SR_BIT);
			#1;
			chk(selfrefresh_2x, 8'(k[2] | (k[1] & k[0])));
		end
		term_case(2'h2, 1'b0, 3'h5);
		term_case(2'h1, 1'b0, 3'h0);
		term_case(2'h0, 1'b0, 3'h5);
		term_case(2'h3, 1'b1, 3'h5);
		beat(3'h0, 1'b1, 1'b1);
		u_ctrl_model.mrs(`SEL_MR_THREE, 17'h00004);
		#1;
		chk(cal_mode, 8'h01);
		for (int k = 0; k < 8; k++) begin
			beat(k[2:0], ~k[0], k[0]);
		end
		// Looked at before reset, which would clear it anyway
		chk(rsvd_write_seen_r, 8'h00);
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		chk(cal_mode, 8'h00);
		chk(write_column_latency, 8'h05);
		end_sim();
	end
endmodule // tb_top
